// ===== hw/frg_pkg.sv
// package: region, path, operation and level encodings for the flash read-protection gate
package frg_pkg;

  typedef enum logic [1:0] {
    FRG_OPEN_LEVEL         = 2'h0,
    FRG_READ_PROTECT_LEVEL = 2'h1,
    FRG_LOCKED_LEVEL       = 2'h2
  } frg_level_e;

  typedef enum logic [2:0] {
    FRG_RGN_MAIN_LOW  = 3'h0,
    FRG_RGN_MAIN_HIGH = 3'h1,
    FRG_RGN_OPTION    = 3'h2,
    FRG_RGN_SYSMEM    = 3'h3,
    FRG_RGN_SRAM      = 3'h4
  } frg_region_e;

  typedef enum logic [1:0] {
    FRG_OP_READ       = 2'h0,
    FRG_OP_PROGRAM    = 2'h1,
    FRG_OP_PAGE_ERASE = 2'h2,
    FRG_OP_MASS_ERASE = 2'h3
  } frg_op_e;

  typedef enum logic {
    FRG_PATH_DEBUG = 1'h0,
    FRG_PATH_CODE  = 1'h1
  } frg_path_e;

  typedef enum logic [1:0] {
    FRG_ST_IDLE  = 2'h0,
    FRG_ST_ERASE = 2'h1
  } frg_state_e;

  localparam int unsigned FRG_ADDR_W         = 32;
  localparam logic [31:0] FRG_MAIN_LOW_LIMIT = 32'h0000_1000;

  typedef struct packed {
    frg_path_e   path;
    frg_region_e region;
    frg_op_e     op;
  } frg_req_s;

  typedef struct packed {
    logic grant;
    logic deny;
  } frg_rsp_s;

endpackage

// ===== hw/frg_gate.sv
// module: access and protection-level gate for flash in system-memory boot
`timescale 1ns/1ns

module frg_gate
  import frg_pkg::*;
#(
  parameter int unsigned ERASE_WAIT_MAX = 16
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       req_valid,
  input  wire frg_req_s   req,
  input  wire logic       lvl_req_valid,
  input  wire frg_level_e lvl_req,
  input  wire logic       mass_erase_done,
  output frg_rsp_s        rsp,
  output logic            rsp_valid,
  output logic            page_erase_go,
  output logic            mass_erase_go,
  output logic            violation,
  output logic            lvl_ack,
  output logic            lvl_nack,
  output frg_level_e      level,
  output logic            debug_enable,
  output logic            busy
);

  function automatic logic allow(input frg_level_e lv, input frg_req_s r);
    logic ok;
    logic dbg;
    ok  = 1'b0;
    dbg = (r.path == FRG_PATH_DEBUG);
    if (r.op == FRG_OP_MASS_ERASE) begin
      ok = !dbg || (lv != FRG_LOCKED_LEVEL);
    end else if (r.region == FRG_RGN_SRAM) begin
      ok = (r.op != FRG_OP_PAGE_ERASE) && !(dbg && lv == FRG_LOCKED_LEVEL);
    end else if (r.region == FRG_RGN_SYSMEM) begin
      ok = !dbg;
    end else if (dbg && lv != FRG_OPEN_LEVEL) begin
      ok = (lv == FRG_READ_PROTECT_LEVEL) && (r.region == FRG_RGN_OPTION);
    end else if (lv == FRG_OPEN_LEVEL) begin
      ok = 1'b1;
    end else if (r.region == FRG_RGN_MAIN_LOW) begin
      ok = (r.op == FRG_OP_READ);
    end else if (r.region == FRG_RGN_OPTION) begin
      ok = (lv != FRG_LOCKED_LEVEL) || (r.op == FRG_OP_READ);
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // level and erase-wait group
  frg_state_e  state_r;
  frg_state_e  state_nxt;
  frg_level_e  level_r;
  frg_level_e  level_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        erase_kick_nxt;
  logic [15:0] wait_r;
  logic [15:0] wait_nxt;
  logic        debug_r;
  logic        debug_nxt;
  logic        busy_r;
  logic        busy_nxt;

  // access response group
  frg_rsp_s    rsp_r;
  frg_rsp_s    rsp_nxt;
  logic        rsp_valid_r;
  logic        rsp_valid_nxt;
  logic        pe_r;
  logic        pe_nxt;
  logic        me_r;
  logic        me_nxt;
  logic        viol_r;
  logic        viol_nxt;

  // request qualifiers
  logic        lvl_take;
  logic        acc_take;
  logic        acc_ok;
  logic        bad_target;

  // a level change wins the cycle; accesses are dropped while erasing
  assign lvl_take   = lvl_req_valid && (state_r == FRG_ST_IDLE);
  assign acc_take   = req_valid && !lvl_req_valid && (state_r == FRG_ST_IDLE);
  assign acc_ok     = allow(level_r, req);
  assign bad_target = !(lvl_req inside {FRG_OPEN_LEVEL, FRG_READ_PROTECT_LEVEL,
                                        FRG_LOCKED_LEVEL});

  always_comb begin
    state_nxt      = state_r;
    level_nxt      = level_r;
    ack_nxt        = 1'b0;
    nack_nxt       = 1'b0;
    erase_kick_nxt = 1'b0;
    wait_nxt       = wait_r;
    case (state_r)
      FRG_ST_IDLE: begin
        if (lvl_take) begin
          if (level_r == FRG_LOCKED_LEVEL) begin
            nack_nxt = 1'b1;
          end else if (bad_target) begin
            nack_nxt = 1'b1;
          end else if (lvl_req == level_r) begin
            nack_nxt = 1'b1;
          end else if (level_r == FRG_READ_PROTECT_LEVEL && lvl_req == FRG_OPEN_LEVEL) begin
            erase_kick_nxt = 1'b1;
            wait_nxt       = '0;
            state_nxt      = FRG_ST_ERASE;
          end else begin
            level_nxt = lvl_req;
            ack_nxt   = 1'b1;
          end
        end
      end
      FRG_ST_ERASE: begin
        // level only drops once main flash is confirmed blank
        if (mass_erase_done) begin
          level_nxt = FRG_OPEN_LEVEL;
          ack_nxt   = 1'b1;
          state_nxt = FRG_ST_IDLE;
        end else if (wait_r == 16'(ERASE_WAIT_MAX)) begin
          erase_kick_nxt = 1'b1; // retry keeps a lost pulse from stalling the downgrade in erase
          wait_nxt       = '0;
        end else begin
          wait_nxt = wait_r + 16'h0001;
        end
      end
      default: begin
        state_nxt = FRG_ST_IDLE;
      end
    endcase
    // status outputs registered so they leave straight from flops
    debug_nxt = (level_nxt != FRG_LOCKED_LEVEL);
    busy_nxt  = (state_nxt == FRG_ST_ERASE);
  end

  always_comb begin
    rsp_nxt       = '0;
    rsp_valid_nxt = 1'b0;
    pe_nxt        = 1'b0;
    me_nxt        = erase_kick_nxt;
    viol_nxt      = 1'b0;
    if (acc_take) begin
      rsp_valid_nxt = 1'b1;
      rsp_nxt.grant = acc_ok;
      rsp_nxt.deny  = !acc_ok;
      viol_nxt      = !acc_ok;
      pe_nxt        = acc_ok && (req.op == FRG_OP_PAGE_ERASE) &&
                      (req.region != FRG_RGN_SRAM);
      me_nxt        = acc_ok && (req.op == FRG_OP_MASS_ERASE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= FRG_ST_IDLE;
      level_r <= FRG_OPEN_LEVEL;
      ack_r   <= 1'b0;
      nack_r  <= 1'b0;
      wait_r  <= '0;
      debug_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      ack_r   <= ack_nxt;
      nack_r  <= nack_nxt;
      wait_r  <= wait_nxt;
      debug_r <= debug_nxt;
      busy_r  <= busy_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r       <= '0;
      rsp_valid_r <= 1'b0;
      pe_r        <= 1'b0;
      me_r        <= 1'b0;
      viol_r      <= 1'b0;
    end else begin
      rsp_r       <= rsp_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      pe_r        <= pe_nxt;
      me_r        <= me_nxt;
      viol_r      <= viol_nxt;
    end
  end

  assign rsp           = rsp_r;
  assign rsp_valid     = rsp_valid_r;
  assign page_erase_go = pe_r;
  assign mass_erase_go = me_r;
  assign violation     = viol_r;
  assign lvl_ack       = ack_r;
  assign lvl_nack      = nack_r;
  assign level         = level_r;
  assign debug_enable  = debug_r;
  assign busy          = busy_r;

endmodule // frg_gate

// ===== dv/frg_flash_model.sv
// flash controller stand-in: finishes a mass erase after DLY cycles
`timescale 1ns/1ns
module frg_flash_model #(parameter int DLY = 3) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic mass_erase_go,
  output logic      mass_erase_done
);
  int cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      mass_erase_done <= 1'b0;
    end else begin
      mass_erase_done <= cnt == 1;
      cnt <= mass_erase_go ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule // frg_flash_model

// ===== dv/frg_gate_asserts.sv
// port checker for the protection gate
`timescale 1ns/1ns
module frg_gate_asserts import frg_pkg::*; (
  input wire logic       clk, nrst, req_valid, lvl_req_valid, mass_erase_done,
  input wire frg_req_s   req,
  input wire frg_level_e lvl_req, level,
  input wire frg_rsp_s   rsp,
  input wire logic       rsp_valid, page_erase_go, mass_erase_go, violation,
  input wire logic       lvl_ack, lvl_nack, debug_enable, busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic lv, ac;
  assign lv = lvl_req_valid && !busy;
  assign ac = req_valid && !lvl_req_valid && !busy;
  AST_RAISE: assert property (lv && level == FRG_OPEN_LEVEL && lvl_req[1] != lvl_req[0]
    |=> lvl_ack && level == $past(lvl_req)) else $error("raise refused");
  AST_RP_LOCK: assert property (lv && level == FRG_READ_PROTECT_LEVEL && lvl_req == 2'h2
    |=> lvl_ack && level == FRG_LOCKED_LEVEL) else $error("lock refused");
  AST_DOWN: assert property (lv && level == FRG_READ_PROTECT_LEVEL && lvl_req == 2'h0
    |=> mass_erase_go && busy && !lvl_ack) else $error("no erase on downgrade");
  AST_DONE: assert property (busy && mass_erase_done
    |=> lvl_ack && level == FRG_OPEN_LEVEL) else $error("downgrade not done");
  AST_FROZEN: assert property (lv && level == FRG_LOCKED_LEVEL
    |=> lvl_nack && $stable(level)) else $error("locked level changed");
  AST_DBG_OFF: assert property ($past(level) == 2'h2 && level == 2'h2 |-> !debug_enable)
    else $error("debug on while locked");
  AST_DENY: assert property (violation |-> rsp_valid && rsp.deny && !rsp.grant)
    else $error("violation without deny");
  AST_SYS: assert property (ac && !req.path && req.region == FRG_RGN_SYSMEM |=> violation)
    else $error("debug reached sysmem");
  AST_MASS: assert property (ac && req.path && req.op == 2'h3 && !req.region[2:1]
    |=> mass_erase_go && rsp.grant) else $error("mass erase refused");
  cover property (lvl_ack && level == FRG_OPEN_LEVEL);
  cover property (lvl_nack);
  cover property (page_erase_go);
endmodule // frg_gate_asserts

// ===== dv/frg_gate_bench.sv
// self-checking bench for the protection gate
`timescale 1ns/1ns
module frg_gate_bench import frg_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, lvl_req_valid = 1'b0;
  logic rsp_valid, page_erase_go, mass_erase_go, mass_erase_done, violation;
  logic lvl_ack, lvl_nack, debug_enable, busy;
  frg_req_s req = '0;
  frg_rsp_s rsp;
  frg_level_e lvl_req = FRG_OPEN_LEVEL, level;
  int n_errors = 0, total_checks = 0;
  always #20 clk = ~clk;
  frg_gate i_frg_gate (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .lvl_req_valid(lvl_req_valid), .lvl_req(lvl_req), .mass_erase_done(mass_erase_done),
    .rsp(rsp), .rsp_valid(rsp_valid), .page_erase_go(page_erase_go),
    .mass_erase_go(mass_erase_go), .violation(violation), .lvl_ack(lvl_ack),
    .lvl_nack(lvl_nack), .level(level), .debug_enable(debug_enable), .busy(busy));
  frg_flash_model i_frg_flash_model (.clk(clk), .nrst(nrst), .mass_erase_go(mass_erase_go),
    .mass_erase_done(mass_erase_done));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string what, logic [4:0] exp, logic [4:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // request stays up so calls run back to back
  task automatic acc(frg_path_e p, frg_region_e r, frg_op_e o, logic [2:0] e);
    req <= '{p, r, o};
    req_valid <= 1'b1;
    @(negedge clk);
    chk("access", {1'b1, e[2], !e[2], e[1:0]},
        {rsp_valid, rsp.grant, violation, page_erase_go, mass_erase_go});
  endtask
  task automatic lvl(frg_level_e t, logic [2:0] e, frg_level_e x);
    int i;
    logic m;
    req_valid <= 1'b0;
    lvl_req <= t;
    lvl_req_valid <= 1'b1;
    @(negedge clk);
    lvl_req_valid <= 1'b0;
    m = mass_erase_go;
    for (i = 0; i < 30 && !(lvl_ack || lvl_nack); i++) @(negedge clk);
    if (i == 30) begin
      n_errors++;
      stop_test();
    end else begin
      chk("level", {e, x}, {lvl_ack, lvl_nack, m, level});
    end
    @(negedge clk);
  endtask
  task automatic t_open();
    chk("reset", 5'h10, {debug_enable, busy, 1'b0, level});
    acc(FRG_PATH_DEBUG, FRG_RGN_MAIN_LOW, FRG_OP_PROGRAM, 3'h4);
    acc(FRG_PATH_DEBUG, FRG_RGN_SYSMEM, FRG_OP_READ, 3'h0);
    acc(FRG_PATH_CODE, FRG_RGN_SYSMEM, FRG_OP_READ, 3'h4);
    lvl(FRG_READ_PROTECT_LEVEL, 3'h4, FRG_READ_PROTECT_LEVEL);
    $display("open done");
  endtask
  task automatic t_rp();
    acc(FRG_PATH_CODE, FRG_RGN_MAIN_LOW, FRG_OP_MASS_ERASE, 3'h5);
    acc(FRG_PATH_DEBUG, FRG_RGN_MAIN_LOW, FRG_OP_READ, 3'h0);
    acc(FRG_PATH_CODE, FRG_RGN_MAIN_LOW, FRG_OP_READ, 3'h4);
    acc(FRG_PATH_CODE, FRG_RGN_MAIN_LOW, FRG_OP_PROGRAM, 3'h0);
    acc(FRG_PATH_DEBUG, FRG_RGN_MAIN_HIGH, FRG_OP_READ, 3'h0);
    acc(FRG_PATH_CODE, FRG_RGN_MAIN_HIGH, FRG_OP_PAGE_ERASE, 3'h6);
    $display("protect done");
  endtask
  task automatic t_lvl();
    lvl(FRG_OPEN_LEVEL, 3'h5, FRG_OPEN_LEVEL);
    lvl(FRG_READ_PROTECT_LEVEL, 3'h4, FRG_READ_PROTECT_LEVEL);
    lvl(FRG_LOCKED_LEVEL, 3'h4, FRG_LOCKED_LEVEL);
    $display("levels done");
  endtask
  task automatic t_lock();
    chk("debug", 5'h0, {4'h0, debug_enable});
    acc(FRG_PATH_CODE, FRG_RGN_OPTION, FRG_OP_PROGRAM, 3'h0);
    acc(FRG_PATH_CODE, FRG_RGN_OPTION, FRG_OP_READ, 3'h4);
    acc(FRG_PATH_CODE, FRG_RGN_MAIN_LOW, FRG_OP_MASS_ERASE, 3'h5);
    lvl(FRG_OPEN_LEVEL, 3'h2, FRG_LOCKED_LEVEL);
    $display("lock done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_open();
    t_rp();
    t_lvl();
    t_lock();
    stop_test();
  end
endmodule // frg_gate_bench
bind frg_gate frg_gate_asserts i_frg_gate_asserts (.clk(clk), .nrst(nrst),
  .req_valid(req_valid), .lvl_req_valid(lvl_req_valid), .mass_erase_done(mass_erase_done),
  .req(req), .lvl_req(lvl_req), .level(level), .rsp(rsp), .rsp_valid(rsp_valid),
  .page_erase_go(page_erase_go), .mass_erase_go(mass_erase_go), .violation(violation),
  .lvl_ack(lvl_ack), .lvl_nack(lvl_nack), .debug_enable(debug_enable), .busy(busy));
